// *** cvf_cfg.svh ***
// Register offsets, field positions, reset values and timing counts
// Assumes APB byte addressing with one 32-bit word per register
`ifndef CVF_CFG_SVH
`define CVF_CFG_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define CVF_OFF_CTL      12'h000
`define CVF_OFF_STAT     12'h004
`define CVF_OFF_MASK     12'h008
`define CVF_OFF_THR      12'h00C
`define CVF_OFF_GAIN     12'h010
`define CVF_OFF_COC      12'h014
`define CVF_OFF_VRES     12'h018
`define CVF_OFF_VOC      12'h01C

// ****************************************************************
// Control fields
// ****************************************************************
`define CVF_CTL_SHUNT    0
`define CVF_CTL_AUTO_GAIN_ENABLE     1
`define CVF_CTL_VSEL     2
`define CVF_CTL_CURRENT_COMP_ENABLE    3
`define CVF_CTL_VOLTAGE_COMP_ENABLE    4
`define CVF_CTL_TSEL     5

// ****************************************************************
// Status fields
// ****************************************************************
`define CVF_ST_OPEN      0
`define CVF_ST_GAINCHG   1

// ****************************************************************
// Reset values and gain limit
// ****************************************************************
`define CVF_RST_CTL      6'h00
`define CVF_RST_THR      8'hF0
`define CVF_RST_GAIN     3'h0
`define CVF_GAIN_MAX     3'h7

// ****************************************************************
// Timing
// ****************************************************************
`define CVF_CLK_MHZ      125
`define CVF_SETTLE_NS    800
`define CVF_SETTLE_CYC   ((`CVF_SETTLE_NS * `CVF_CLK_MHZ) / 1000)

`endif

// *** cvf_pkg.sv ***
// Types shared by the channel front control
// Assumes cvf_cfg.svh for numeric constants
`default_nettype none
package cvf_pkg;
  typedef struct packed {
    logic [2:0] gain;
    logic       shunt_en;
    logic       vsel;
    logic       tsel;
    logic       current_comp_enable_en;
    logic       voltage_comp_enable_en;
  } cvf_afe_ctl_s;

  typedef struct packed {
    logic [3:0] level;
    logic       valid;
    logic       shunt_open;
  } cvf_afe_stat_s;

  typedef enum logic [1:0] {
    CVF_AG_IDLE   = 2'b00,
    CVF_AG_SETTLE = 2'b01
  } cvf_ag_state_e;
endpackage
`default_nettype wire

// *** cvf_front_ctl.sv ***
// Current / voltage channel front control with APB registers
// Assumes analog front end on pclk domain sources; raw pins are synchronised here
//
// Overview of operation
// - Three channels: current, voltage, temperature with sharing
// - Current and voltage share conditioning and timing
// - Voltage channel samples battery sense after reset
// - Shunt-detect enable bit activates open monitoring
// - Open shunt sets status flag while monitoring
// - Eight gain settings in three-bit field
// - Up threshold (n+1)/16, down threshold n/16
// - Auto gain steps to adjacent level
// - Gain field reads active gain
// - Auto adjustment sets gain-changed flag
// - Clearing auto enable freezes gain
// - Manual gain write when auto disabled
// - Eight offset buffers selected by gain
// - Select bit steers voltage mux, shared divider
// - One shared voltage result register
// - Compensation enable bits route or bypass stages
`include "cvf_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module cvf_front_ctl
  import cvf_pkg::*;
(
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [11:0]   paddr,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  input  wire cvf_afe_stat_s afe_stat,
  input  wire logic [15:0]   vres_data,
  input  wire logic          vres_valid,
  output cvf_afe_ctl_s       afe_ctl,
  output logic [7:0]         coc_out,
  output logic [7:0]         voc_out,
  output logic               irq
);

  // ****************************************************************
  // Synchronisers for analog-side levels
  // ****************************************************************
  cvf_afe_stat_s stat_s1_reg;
  cvf_afe_stat_s stat_s2_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_s1_reg <= '0;
      stat_s2_reg <= '0;
    end else begin
      stat_s1_reg <= afe_stat;
      stat_s2_reg <= stat_s1_reg;
    end
  end

  // ****************************************************************
  // APB decode
  // ****************************************************************
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  assign wr_en   = psel && penable && pwrite;
  assign rd_en   = psel && penable && !pwrite;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    hit = (a == off);
  endfunction

  assign addr_ok = hit(paddr, `CVF_OFF_CTL) || hit(paddr, `CVF_OFF_STAT) ||
                   hit(paddr, `CVF_OFF_MASK) || hit(paddr, `CVF_OFF_THR) ||
                   hit(paddr, `CVF_OFF_GAIN) || hit(paddr, `CVF_OFF_COC) ||
                   hit(paddr, `CVF_OFF_VRES) || hit(paddr, `CVF_OFF_VOC);

  // ****************************************************************
  // Control, threshold, mask and voltage offset registers
  // ****************************************************************
  logic [5:0] ctl_reg;
  logic [7:0] thr_reg;
  logic [1:0] mask_reg;
  logic [7:0] voc_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_reg  <= `CVF_RST_CTL;
      thr_reg  <= `CVF_RST_THR;
      mask_reg <= 2'h0;
      voc_reg  <= 8'h00;
    end else if (wr_en) begin
      if (hit(paddr, `CVF_OFF_CTL))
        ctl_reg <= pwdata[5:0];
      if (hit(paddr, `CVF_OFF_THR))
        thr_reg <= pwdata[7:0];
      if (hit(paddr, `CVF_OFF_MASK))
        mask_reg <= pwdata[1:0];
      // Single buffer: software reloads it after a mux change
      if (hit(paddr, `CVF_OFF_VOC))
        voc_reg <= pwdata[7:0];
    end
  end

  // ****************************************************************
  // Automatic gain unit
  // ****************************************************************
  // Level compared is absolute amplifier output in 1/16 of reference.
  // After a step the amplifier settles before the next comparison,
  // which keeps a marginal signal from ringing between two gains.
  logic [3:0]     up_thr;
  logic [3:0]     dn_thr;
  logic [4:0]     up_cmp;
  logic           go_up;
  logic           go_dn;
  logic [2:0]     gain_reg;
  logic           step_pulse;
  cvf_ag_state_e  ag_state_reg;
  logic [7:0]     settle_reg;
  logic           auto_gain_enable;

  assign auto_gain_enable   = ctl_reg[`CVF_CTL_AUTO_GAIN_ENABLE];
  assign up_thr = thr_reg[7:4];
  assign dn_thr = thr_reg[3:0];
  assign up_cmp = {1'b0, up_thr} + 5'h01;
  // Up on reaching (n+1)/16; down on falling below n/16
  assign go_up  = stat_s2_reg.valid && ({1'b0, stat_s2_reg.level} >= up_cmp)
                  && (gain_reg != `CVF_GAIN_MAX);
  assign go_dn  = stat_s2_reg.valid && (stat_s2_reg.level < dn_thr)
                  && (gain_reg != `CVF_RST_GAIN);
  assign step_pulse = auto_gain_enable && (ag_state_reg == CVF_AG_IDLE) && (go_up || go_dn);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ag_state_reg <= CVF_AG_IDLE;
      settle_reg   <= 8'h00;
    end else begin
      unique case (ag_state_reg)
        CVF_AG_IDLE: begin
          if (step_pulse) begin
            ag_state_reg <= CVF_AG_SETTLE;
            settle_reg   <= 8'(`CVF_SETTLE_CYC - 1);
          end
        end
        CVF_AG_SETTLE: begin
          if (settle_reg == 8'h00)
            ag_state_reg <= CVF_AG_IDLE;
          else
            settle_reg <= settle_reg - 8'h01;
        end
      endcase
    end
  end

  // Gain: auto steps, or manual write when auto is off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gain_reg <= `CVF_RST_GAIN;
    end else if (step_pulse) begin
      if (go_up)
        gain_reg <= gain_reg + 3'h1;
      else
        gain_reg <= gain_reg - 3'h1;
    end else if (wr_en && !auto_gain_enable && hit(paddr, `CVF_OFF_GAIN)) begin
      gain_reg <= pwdata[2:0];
    end
  end

  // ****************************************************************
  // Offset compensation buffers, one per gain
  // ****************************************************************
  logic [7:0] coc_mem [8];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 8; i++)
        coc_mem[i] <= 8'h00;
    end else if (wr_en && hit(paddr, `CVF_OFF_COC)) begin
      coc_mem[gain_reg] <= pwdata[7:0];
    end
  end

  // ****************************************************************
  // Voltage result, shared by both sources
  // ****************************************************************
  logic [15:0] vres_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      vres_reg <= 16'h0000;
    else if (vres_valid)
      vres_reg <= vres_data;
  end

  // ****************************************************************
  // Sticky status, mask and interrupt
  // ****************************************************************
  logic [1:0] stat_reg;
  logic [1:0] stat_set;
  logic [1:0] stat_clr;

  assign stat_set[`CVF_ST_OPEN]    = ctl_reg[`CVF_CTL_SHUNT] && stat_s2_reg.shunt_open;
  assign stat_set[`CVF_ST_GAINCHG] = step_pulse;
  assign stat_clr = (wr_en && hit(paddr, `CVF_OFF_STAT)) ? pwdata[1:0] : 2'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      stat_reg <= 2'h0;
    else
      stat_reg <= (stat_reg & ~stat_clr) | stat_set; // Set wins over clear
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      irq <= 1'b0;
    else
      irq <= |(((stat_reg & ~stat_clr) | stat_set) & mask_reg);
  end

  // ****************************************************************
  // Analog control outputs
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      afe_ctl <= '0;
      coc_out <= 8'h00;
      voc_out <= 8'h00;
    end else begin
      afe_ctl.gain     <= gain_reg;
      afe_ctl.shunt_en <= ctl_reg[`CVF_CTL_SHUNT];
      afe_ctl.vsel     <= ctl_reg[`CVF_CTL_VSEL];
      afe_ctl.tsel     <= ctl_reg[`CVF_CTL_TSEL];
      afe_ctl.current_comp_enable_en <= ctl_reg[`CVF_CTL_CURRENT_COMP_ENABLE];
      afe_ctl.voltage_comp_enable_en <= ctl_reg[`CVF_CTL_VOLTAGE_COMP_ENABLE];
      // Zero offset while bypassed so the stage is transparent
      coc_out <= ctl_reg[`CVF_CTL_CURRENT_COMP_ENABLE] ? coc_mem[gain_reg] : 8'h00;
      voc_out <= ctl_reg[`CVF_CTL_VOLTAGE_COMP_ENABLE] ? voc_reg : 8'h00;
    end
  end

  // ****************************************************************
  // APB read and response
  // ****************************************************************
  logic [31:0] rd_mux;

  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (paddr)
      `CVF_OFF_CTL:  rd_mux = {26'h0, ctl_reg};
      `CVF_OFF_STAT: rd_mux = {30'h0, stat_reg};
      `CVF_OFF_MASK: rd_mux = {30'h0, mask_reg};
      `CVF_OFF_THR:  rd_mux = {24'h0, thr_reg};
      `CVF_OFF_GAIN: rd_mux = {29'h0, gain_reg};
      `CVF_OFF_COC:  rd_mux = {24'h0, coc_mem[gain_reg]};
      `CVF_OFF_VRES: rd_mux = {16'h0, vres_reg};
      `CVF_OFF_VOC:  rd_mux = {24'h0, voc_reg};
      default:       rd_mux = 32'h0000_0000;
    endcase
  end

  // Zero-wait slave: registered signals come ready in the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !addr_ok;
      if (psel && !penable && !pwrite)
        prdata <= rd_mux;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_gain_manual_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !auto_gain_enable && !(wr_en && hit(paddr, `CVF_OFF_GAIN)) |=> $stable(gain_reg))
    else $error("gain moved with auto off");
  a_gain_manual_set: assert property (@(posedge pclk) disable iff (!presetn)
    !auto_gain_enable && wr_en && hit(paddr, `CVF_OFF_GAIN) |=> gain_reg == $past(pwdata[2:0]))
    else $error("manual gain not applied");
  a_gain_step_one: assert property (@(posedge pclk) disable iff (!presetn)
    step_pulse && go_up |=> gain_reg == $past(gain_reg) + 3'h1)
    else $error("gain step up wrong");
  // Auto steps never wrap; a manual write may jump anywhere
  a_gain_no_wrap: assert property (@(posedge pclk) disable iff (!presetn)
    auto_gain_enable && gain_reg == `CVF_GAIN_MAX |=> gain_reg != `CVF_RST_GAIN)
    else $error("gain wrapped");
  a_gainchg_flag: assert property (@(posedge pclk) disable iff (!presetn)
    step_pulse |=> stat_reg[`CVF_ST_GAINCHG])
    else $error("gain flag not set");
  a_open_flag: assert property (@(posedge pclk) disable iff (!presetn)
    !ctl_reg[`CVF_CTL_SHUNT] && !stat_reg[`CVF_ST_OPEN] |=> !stat_reg[`CVF_ST_OPEN])
    else $error("open flag without monitor");
  a_gain_out: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1 |=> afe_ctl.gain == $past(gain_reg))
    else $error("gain out mismatch");
  a_vsel_out: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(ctl_reg[`CVF_CTL_VSEL]) |=> afe_ctl.vsel)
    else $error("mux select not driven");
  a_bypass_zero: assert property (@(posedge pclk) disable iff (!presetn)
    !ctl_reg[`CVF_CTL_CURRENT_COMP_ENABLE] |=> coc_out == 8'h00)
    else $error("offset not bypassed");
  a_gain_step_down: assert property (@(posedge pclk) disable iff (!presetn)
    step_pulse && !go_up |=> gain_reg == $past(gain_reg) - 3'h1)
    else $error("gain step down wrong");
  a_gain_floor_hold: assert property (@(posedge pclk) disable iff (!presetn)
    auto_gain_enable && gain_reg == `CVF_RST_GAIN |=> gain_reg != `CVF_GAIN_MAX)
    else $error("gain wrapped below zero");
  a_gain_auto_lock: assert property (@(posedge pclk) disable iff (!presetn)
    auto_gain_enable && !step_pulse |=> $stable(gain_reg))
    else $error("gain moved without a step");
  a_settle_start: assert property (@(posedge pclk) disable iff (!presetn)
    step_pulse |=> ag_state_reg == CVF_AG_SETTLE)
    else $error("no settle after step");
  a_shunt_out: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1 |=> afe_ctl.shunt_en == $past(ctl_reg[`CVF_CTL_SHUNT]))
    else $error("shunt monitor enable not driven");
  a_tsel_out: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1 |=> afe_ctl.tsel == $past(ctl_reg[`CVF_CTL_TSEL]))
    else $error("temperature select not driven");
  a_comp_out: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1 |=> afe_ctl.current_comp_enable_en == $past(ctl_reg[`CVF_CTL_CURRENT_COMP_ENABLE])
    && afe_ctl.voltage_comp_enable_en == $past(ctl_reg[`CVF_CTL_VOLTAGE_COMP_ENABLE]))
    else $error("compensation enables not driven");
  a_vbypass_zero: assert property (@(posedge pclk) disable iff (!presetn)
    !ctl_reg[`CVF_CTL_VOLTAGE_COMP_ENABLE] |=> voc_out == 8'h00)
    else $error("voltage offset not bypassed");
  a_coc_route: assert property (@(posedge pclk) disable iff (!presetn)
    ctl_reg[`CVF_CTL_CURRENT_COMP_ENABLE] |=> coc_out == $past(coc_mem[gain_reg]))
    else $error("offset buffer of active gain not routed");
  a_voc_route: assert property (@(posedge pclk) disable iff (!presetn)
    ctl_reg[`CVF_CTL_VOLTAGE_COMP_ENABLE] |=> voc_out == $past(voc_reg))
    else $error("voltage offset not routed");
  a_coc_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && hit(paddr, `CVF_OFF_COC)
    |=> coc_mem[$past(gain_reg)] == $past(pwdata[7:0]))
    else $error("offset buffer write missed");
  a_vres_load: assert property (@(posedge pclk) disable iff (!presetn)
    vres_valid |=> vres_reg == $past(vres_data))
    else $error("voltage result not loaded");
  a_vres_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !vres_valid |=> $stable(vres_reg))
    else $error("voltage result changed without a result");
  a_open_set: assert property (@(posedge pclk) disable iff (!presetn)
    ctl_reg[`CVF_CTL_SHUNT] && stat_s2_reg.shunt_open |=> stat_reg[`CVF_ST_OPEN])
    else $error("open shunt not flagged");
  a_open_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    stat_reg[`CVF_ST_OPEN] && !stat_clr[`CVF_ST_OPEN] |=> stat_reg[`CVF_ST_OPEN])
    else $error("open flag dropped without clear");
  a_gainchg_cause: assert property (@(posedge pclk) disable iff (!presetn)
    !step_pulse && !stat_reg[`CVF_ST_GAINCHG] |=> !stat_reg[`CVF_ST_GAINCHG])
    else $error("gain flag set without a step");
  a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1 |=> irq == |(stat_reg & $past(mask_reg)))
    else $error("interrupt level wrong");
  a_ready_wait: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable |=> pready)
    else $error("bus answer late");
  a_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable && !addr_ok |=> pready && pslverr)
    else $error("unmapped access not refused");
  a_gain_read: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable && !pwrite && hit(paddr, `CVF_OFF_GAIN)
    |=> prdata == {29'h0, $past(gain_reg)})
    else $error("gain field read wrong");

endmodule // cvf_front_ctl
`default_nettype wire

// *** cvf_afe_model.sv ***
// Behavioural analog front end: amplifier level, shunt sense, voltage converter
// Assumes the bench commands the level and the shunt state on pclk edges
`timescale 1ns/1ps
`default_nettype none

module cvf_afe_model
  import cvf_pkg::*;
#(
  parameter logic [15:0] BAT_CODE = 16'h5E45,
  parameter logic [15:0] EXT_CODE = 16'hB00B
)(
  input  wire logic          pclk,
  input  wire cvf_afe_ctl_s  afe_ctl,
  input  wire logic [3:0]    level_cmd,
  input  wire logic          open_cmd,
  input  wire logic          conv_req,
  output cvf_afe_stat_s      afe_stat,
  output logic [15:0]        vres_data,
  output logic               vres_valid
);
  // Sense only reports while enabled, as the real comparator does
  assign afe_stat = '{level: level_cmd, valid: 1'b1,
                      shunt_open: afe_ctl.shunt_en & open_cmd};

  // Outside a result the data lines show the inverse, so stale values never match
  logic [15:0] src_code;
  assign src_code = afe_ctl.vsel ? EXT_CODE : BAT_CODE;

  always_ff @(posedge pclk) begin
    vres_valid <= conv_req;
    vres_data  <= conv_req ? src_code : ~src_code;
  end
endmodule // cvf_afe_model
`default_nettype wire

// *** current_voltage_channel_front_control_bench.sv ***
// Self-checking bench for the channel front control over APB
// Assumes cvf_afe_model as the analog side and zero-wait APB answers
`include "cvf_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module current_voltage_channel_front_control_bench;
  import cvf_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, open_cmd, conv_req, last_err, pready, pslverr, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [3:0] level_cmd;
  logic [15:0] vres_data;
  logic vres_valid;
  logic [7:0] coc_out, voc_out;
  cvf_afe_stat_s afe_stat;
  cvf_afe_ctl_s afe_ctl;
  int n_errors, checks_done, g;

  cvf_front_ctl cvf_front_ctl_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .afe_stat(afe_stat), .vres_data(vres_data),
    .vres_valid(vres_valid), .afe_ctl(afe_ctl), .coc_out(coc_out), .voc_out(voc_out),
    .irq(irq));
  cvf_afe_model cvf_afe_model_inst (.pclk(pclk), .afe_ctl(afe_ctl), .level_cmd(level_cmd),
    .open_cmd(open_cmd), .conv_req(conv_req), .afe_stat(afe_stat), .vres_data(vres_data),
    .vres_valid(vres_valid));

  // ****************************************************************
  // Bus tasks and comparison
  // ****************************************************************
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Entered just after an edge; one idle edge at the end keeps drivers apart
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int i;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (pready !== 1'b1) begin
      n_errors++;
      report_and_stop();
    end
    q = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic chk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(q, exp);
  endtask

  // Bounded poll of the gain field
  task automatic wait_gain(input logic [2:0] gv);
    for (int i = 0; i < 400; i++) begin
      apb(1'b0, `CVF_OFF_GAIN, 32'h0);
      if (q[2:0] === gv) break;
    end
    check(q, {29'h0, gv});
  endtask

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial begin
    {presetn, psel, penable, pwrite, open_cmd, conv_req} = 6'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    level_cmd = 4'h0;
    n_errors = 0;
    checks_done = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(`CVF_OFF_CTL, 32'h0);
    chk(`CVF_OFF_THR, {24'h0, `CVF_RST_THR});
    chk(`CVF_OFF_GAIN, 32'h0);
    check({31'h0, afe_ctl.vsel}, 32'h0);
    chk(12'hFFC, 32'h0);
    check({31'h0, last_err}, 32'h1);
    $display("test reset done");
    for (g = 0; g < 8; g++) begin
      apb(1'b1, `CVF_OFF_GAIN, g);
      apb(1'b1, `CVF_OFF_COC, 32'h10 + g);
    end
    for (g = 0; g < 8; g++) begin
      apb(1'b1, `CVF_OFF_GAIN, g);
      chk(`CVF_OFF_COC, 32'h10 + g);
      check({29'h0, afe_ctl.gain}, g);
    end
    apb(1'b1, `CVF_OFF_CTL, 32'h28);
    repeat (2) @(posedge pclk);
    check({24'h0, coc_out}, 32'h17);
    check({24'h0, afe_ctl}, 32'hE6);
    $display("test manual gain done");
    apb(1'b1, `CVF_OFF_MASK, 32'h3);
    open_cmd <= 1'b1;
    repeat (6) @(posedge pclk);
    chk(`CVF_OFF_STAT, 32'h0);
    apb(1'b1, `CVF_OFF_CTL, 32'h1);
    repeat (6) @(posedge pclk);
    chk(`CVF_OFF_STAT, 32'h1);
    check({31'h0, afe_ctl.shunt_en}, 32'h1);
    check({31'h0, irq}, 32'h1);
    apb(1'b1, `CVF_OFF_MASK, 32'h0);
    repeat (2) @(posedge pclk);
    check({31'h0, irq}, 32'h0);
    open_cmd <= 1'b0;
    apb(1'b1, `CVF_OFF_CTL, 32'h0);
    repeat (6) @(posedge pclk);
    apb(1'b1, `CVF_OFF_STAT, 32'h1);
    chk(`CVF_OFF_STAT, 32'h0);
    $display("test shunt done");
    for (g = 0; g < 2; g++) begin
      apb(1'b1, `CVF_OFF_CTL, {27'h0, 1'b1, 1'b0, g[0], 2'b00});
      // Software owns the single offset buffer across a mux change
      apb(1'b1, `CVF_OFF_VOC, 32'h20 + g);
      @(posedge pclk);
      check({31'h0, afe_ctl.vsel}, g);
      check({24'h0, voc_out}, 32'h20 + g);
      conv_req <= 1'b1;
      @(posedge pclk);
      conv_req <= 1'b0;
      repeat (3) @(posedge pclk);
      chk(`CVF_OFF_VRES, g ? 32'hB00B : 32'h5E45);
    end
    $display("test voltage select done");
    apb(1'b1, `CVF_OFF_CTL, 32'h0);
    apb(1'b1, `CVF_OFF_GAIN, 32'h6);
    apb(1'b1, `CVF_OFF_THR, 32'h31);
    apb(1'b1, `CVF_OFF_MASK, 32'h2);
    level_cmd <= 4'h4;
    apb(1'b1, `CVF_OFF_CTL, 32'h2);
    wait_gain(3'h7);
    repeat (4) @(posedge pclk);
    check({29'h0, afe_ctl.gain}, 32'h7);
    chk(`CVF_OFF_STAT, 32'h2);
    check({31'h0, irq}, 32'h1);
    apb(1'b1, `CVF_OFF_GAIN, 32'h5);
    level_cmd <= 4'h3;
    repeat (300) @(posedge pclk);
    chk(`CVF_OFF_GAIN, 32'h7);
    level_cmd <= 4'h0;
    wait_gain(3'h0);
    apb(1'b1, `CVF_OFF_CTL, 32'h0);
    level_cmd <= 4'hF;
    repeat (300) @(posedge pclk);
    chk(`CVF_OFF_GAIN, 32'h0);
    $display("test auto gain done");
    report_and_stop();
  end
endmodule // current_voltage_channel_front_control_bench
`default_nettype wire
